// File: rstc_pkg.sv
// package: register map, field positions and reset values of the reset cause block
// assumes: apb slave with 32-bit data, one aligned word per register
`default_nettype none
package rstc_pkg;
    // byte offsets on the apb bus
    localparam logic [7:0]  OFF_RESET_CAUSE_CONTROL = 8'h00;
    localparam logic [7:0]  OFF_IRQ_STATUS          = 8'h04;
    localparam logic [7:0]  OFF_IRQ_MASK            = 8'h08;
    // field positions of reset_cause_control
    localparam int unsigned BIT_TRAP    = 15;
    localparam int unsigned BIT_BADOP   = 14;
    localparam int unsigned BIT_FLASHRG = 11;
    localparam int unsigned BIT_CFGMIS  = 9;
    localparam int unsigned BIT_MAINRG  = 8;
    localparam int unsigned BIT_PIN     = 7;
    localparam int unsigned BIT_SOFT    = 6;
    localparam int unsigned BIT_SOFT_WATCHDOG_ENABLE  = 5;
    localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG    = 4;
    localparam int unsigned BIT_SLEEP   = 3;
    localparam int unsigned BIT_IDLE    = 2;
    localparam int unsigned BIT_BOR     = 1;
    localparam int unsigned BIT_POR     = 0;
    // implemented bits; 13, 12 and 10 read zero
    localparam logic [15:0] IMPL_MASK   = 16'hcbff;
    // cause flags that hardware sets
    localparam logic [15:0] FLAG_MASK   = 16'hc2df;
    localparam logic [15:0] RCC_RESET   = 16'h0003;
    localparam logic [15:0] MASK_RESET  = 16'h0000;
    localparam int unsigned EVT_W       = 16;
endpackage : rstc_pkg
`default_nettype wire

// File: rstc_evt_if.sv
// interface: event pulses from the capture stage to the register file
// assumes: one clock domain, pulses one cycle long
`timescale 1ns/1ps
`default_nettype none
interface rstc_evt_if;
    logic [15:0] evt;   // one-cycle set pulses, register bit layout
    modport src (output evt);
    modport dst (input  evt);
endinterface : rstc_evt_if
`default_nettype wire

// File: rstc_sync.sv
// module: two-flop synchronisers plus rising-edge pulse for each cause input
// assumes: inputs may be asynchronous to SYS_CLK
`timescale 1ns/1ps
`default_nettype none
module rstc_sync #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] raw,
    rstc_evt_if.src           ev
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // only s2_r and its delayed copy s3_r feed the edge detector, s1_r stays private
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a held level counts once, so software can clear it while it stays high
    assign ev.evt = s2_r & ~s3_r;
endmodule : rstc_sync
`default_nettype wire

// File: rstc_top.sv
// top: reset cause and control register with apb slave and interrupt
// assumes: reset logic drives cause inputs; SYS_RST is the core reset
//
// Contract
// RULE1 - trap conflict reset sets bit 15
// RULE2 - illegal opcode, addressing or uninitialised pointer sets bit 14
// RULE3 - bits 13, 12, 10 read zero and ignore writes
// RULE4 - bit 11 one keeps flash regulator active in sleep
// RULE5 - configuration mismatch reset sets bit 9
// RULE6 - bit 8 one keeps main regulator active in sleep
// RULE7 - master clear pin reset sets bit 7
// RULE8 - software reset instruction sets bit 6
// RULE9 - bit 5 enables the watchdog by software
// RULE10 - watchdog time-out sets bit 4
// RULE11 - software sets or clears any flag, never causing a reset
// RULE12 - unprogrammed fuse keeps watchdog running regardless of bit 5
// RULE13 - power-on sets bits 0 and 1, value 0x0003
// RULE14 - flags persist across other resets; bits 3, 2 record sleep, idle
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rstc_top (
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        POWER_ON_RST,
    input  wire logic        TRAP_CONFLICT,
    input  wire logic        BAD_OPCODE_POINTER,
    input  wire logic        CONFIG_MISMATCH,
    input  wire logic        MASTER_CLEAR_PIN,
    input  wire logic        SOFT_RESET,
    input  wire logic        WATCHDOG_TIMEOUT,
    input  wire logic        BROWNOUT,
    input  wire logic        SLEEP_WAKE,
    input  wire logic        IDLE_WAKE,
    input  wire logic        WATCHDOG_FUSE_ENABLE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             WATCHDOG_RUN,
    output logic             FLASH_REGULATOR_SLEEP_KEEP,
    output logic             MAIN_REGULATOR_SLEEP_KEEP,
    output logic             IRQ
);
    logic [15:0] rcc_r;
    logic [15:0] rcc_nxt;
    logic [15:0] irq_stat_r;
    logic [15:0] irq_stat_nxt;
    logic [15:0] irq_mask_r;
    logic [15:0] raw_evt;
    logic        fuse_s1_r;
    logic        fuse_s2_r;
    logic        wdt_run_r;
    logic [31:0] prdata_r;
    logic        wr_en;
    logic        rd_en;
    logic        hit_rcc;
    logic        hit_st;
    logic        hit_mk;

    rstc_evt_if evt_bus ();

    // byte-lane merge; used for every writable register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0])
            res[7:0] = wd[7:0];
        if (strb[1])
            res[15:8] = wd[15:8];
        return res;
    endfunction

    // map each cause input onto its register bit
    always_comb
    begin
        raw_evt                        = '0;
        // RULE1 trap conflict cause
        raw_evt[rstc_pkg::BIT_TRAP]    = TRAP_CONFLICT;
        // RULE2 bad opcode cause
        raw_evt[rstc_pkg::BIT_BADOP]   = BAD_OPCODE_POINTER;
        // RULE5 mismatch cause
        raw_evt[rstc_pkg::BIT_CFGMIS]  = CONFIG_MISMATCH;
        // RULE7 pin reset cause
        raw_evt[rstc_pkg::BIT_PIN]     = MASTER_CLEAR_PIN;
        // RULE8 software reset cause
        raw_evt[rstc_pkg::BIT_SOFT]    = SOFT_RESET;
        // RULE10 watchdog cause
        raw_evt[rstc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]    = WATCHDOG_TIMEOUT;
        // RULE14 wake status causes
        raw_evt[rstc_pkg::BIT_SLEEP]   = SLEEP_WAKE;
        raw_evt[rstc_pkg::BIT_IDLE]    = IDLE_WAKE;
        raw_evt[rstc_pkg::BIT_BOR]     = BROWNOUT;
        raw_evt[rstc_pkg::BIT_POR]     = POWER_ON_RST;
    end

    rstc_sync #(
        .W   (rstc_pkg::EVT_W)
    ) u_sync (
        .clk (SYS_CLK),
        .rst (SYS_RST),
        .raw (raw_evt),
        .ev  (evt_bus.src)
    );

    // apb decode: zero-wait slave, unmapped reads zero with error
    assign hit_rcc = PADDR == rstc_pkg::OFF_RESET_CAUSE_CONTROL;
    assign hit_st  = PADDR == rstc_pkg::OFF_IRQ_STATUS;
    assign hit_mk  = PADDR == rstc_pkg::OFF_IRQ_MASK;
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign rd_en   = PSEL && !PENABLE && !PWRITE;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(hit_rcc || hit_st || hit_mk);

    // next register value: software write first, hardware set wins
    always_comb
    begin
        rcc_nxt = rcc_r;
        // RULE11 software may set or clear flags; no reset output exists
        if (wr_en && hit_rcc)
            rcc_nxt = merge16(rcc_r, PWDATA, PSTRB);
        // RULE14 flags are only ever set by events, never cleared by them
        rcc_nxt = rcc_nxt | (evt_bus.evt & rstc_pkg::FLAG_MASK);
        // RULE3 unimplemented bits forced low
        rcc_nxt = rcc_nxt & rstc_pkg::IMPL_MASK;
    end

    // SYS_RST leaves flags alone so causes survive core resets; power-on loads 0x0003
    always_ff @(posedge SYS_CLK)
    begin
        // RULE13 power-on value
        if (POWER_ON_RST)
            rcc_r <= rstc_pkg::RCC_RESET;
        else
            rcc_r <= rcc_nxt;
    end

    // interrupt status: write one to clear, a new event in the same cycle wins
    always_comb
    begin
        irq_stat_nxt = irq_stat_r;
        if (wr_en && hit_st)
            irq_stat_nxt = irq_stat_r & ~merge16(16'h0000, PWDATA, PSTRB);
        irq_stat_nxt = irq_stat_nxt | (evt_bus.evt & rstc_pkg::FLAG_MASK);
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            irq_stat_r <= rstc_pkg::MASK_RESET;
        else
            irq_stat_r <= irq_stat_nxt;
    end

    // interrupt mask, same layout as status
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            irq_mask_r <= rstc_pkg::MASK_RESET;
        else if (wr_en && hit_mk)
            irq_mask_r <= merge16(irq_mask_r, PWDATA, PSTRB) & rstc_pkg::FLAG_MASK;
    end

    assign IRQ = |(irq_stat_r & irq_mask_r);

    // fuse is a strap from outside; synchronise before use
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
        begin
            fuse_s1_r <= 1'b0;
            fuse_s2_r <= 1'b0;
        end
        else
        begin
            fuse_s1_r <= WATCHDOG_FUSE_ENABLE;
            fuse_s2_r <= fuse_s1_r;
        end
    end

    // watchdog run level
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            wdt_run_r <= 1'b0;
        else
            // RULE12 fuse override, RULE9 software enable
            wdt_run_r <= fuse_s2_r | rcc_r[rstc_pkg::BIT_SOFT_WATCHDOG_ENABLE];
    end
    assign WATCHDOG_RUN = wdt_run_r;

    // RULE4 flash regulator keep, RULE6 main regulator keep
    assign FLASH_REGULATOR_SLEEP_KEEP = rcc_r[rstc_pkg::BIT_FLASHRG];
    assign MAIN_REGULATOR_SLEEP_KEEP  = rcc_r[rstc_pkg::BIT_MAINRG];

    // read data captured in setup, stable through access
    always_ff @(posedge SYS_CLK)
    begin
        if (SYS_RST)
            prdata_r <= '0;
        else if (rd_en)
        begin
            if (hit_rcc)
                prdata_r <= {16'h0000, rcc_r};
            else if (hit_st)
                prdata_r <= {16'h0000, irq_stat_r};
            else if (hit_mk)
                prdata_r <= {16'h0000, irq_mask_r};
            else
                prdata_r <= '0;
        end
    end
    assign PRDATA = prdata_r;

    // checks
    // event capture takes three edges: two sync stages, then the edge pulse lands in the flag
    sequence s_trap_rise;
        $rose(TRAP_CONFLICT);
    endsequence

    sequence s_trap_landed;
        ##3 rcc_r[rstc_pkg::BIT_TRAP];
    endsequence

    a_unimpl_zero: assert property (@(posedge SYS_CLK) // RULE3
        disable iff (POWER_ON_RST)
        (rcc_r & ~rstc_pkg::IMPL_MASK) == 16'h0000)
        else $error("unimplemented bits set");
    a_trap_sets: assert property (@(posedge SYS_CLK) // RULE1
        disable iff (SYS_RST || POWER_ON_RST)
        s_trap_rise |-> s_trap_landed)
        else $error("trap flag not set");
    a_trap_status: assert property (@(posedge SYS_CLK) // RULE1
        disable iff (SYS_RST)
        evt_bus.evt[rstc_pkg::BIT_TRAP] |=> irq_stat_r[rstc_pkg::BIT_TRAP])
        else $error("trap status not set");
    a_badop_sets: assert property (@(posedge SYS_CLK) // RULE2
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_BADOP] |=> rcc_r[rstc_pkg::BIT_BADOP])
        else $error("bad opcode flag not set");
    a_cfg_sets: assert property (@(posedge SYS_CLK) // RULE5
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_CFGMIS] |=> rcc_r[rstc_pkg::BIT_CFGMIS])
        else $error("mismatch flag not set");
    a_pin_sets: assert property (@(posedge SYS_CLK) // RULE7
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_PIN] |=> rcc_r[rstc_pkg::BIT_PIN])
        else $error("pin flag not set");
    a_soft_sets: assert property (@(posedge SYS_CLK) // RULE8
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_SOFT] |=> rcc_r[rstc_pkg::BIT_SOFT])
        else $error("soft reset flag not set");
    a_watchdog_timeout_flag_sets: assert property (@(posedge SYS_CLK) // RULE10
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] |=> rcc_r[rstc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not set");

    // wake and brown-out flags use the same single-edge capture as the causes
    a_sleep_sets: assert property (@(posedge SYS_CLK) // RULE14
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_SLEEP] |=> rcc_r[rstc_pkg::BIT_SLEEP])
        else $error("sleep flag not set");
    a_idle_sets: assert property (@(posedge SYS_CLK) // RULE14
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_IDLE] |=> rcc_r[rstc_pkg::BIT_IDLE])
        else $error("idle flag not set");
    a_bor_sets: assert property (@(posedge SYS_CLK) // RULE14
        disable iff (SYS_RST || POWER_ON_RST)
        evt_bus.evt[rstc_pkg::BIT_BOR] |=> rcc_r[rstc_pkg::BIT_BOR])
        else $error("brown-out flag not set");
    a_por_value: assert property (@(posedge SYS_CLK) // RULE13
        POWER_ON_RST |=> rcc_r == rstc_pkg::RCC_RESET)
        else $error("power-on value wrong");
    a_fuse_run: assert property (@(posedge SYS_CLK) // RULE12
        disable iff (SYS_RST)
        fuse_s2_r |=> WATCHDOG_RUN)
        else $error("fuse does not force watchdog");
    a_swdt_ctrl: assert property (@(posedge SYS_CLK) // RULE9
        disable iff (SYS_RST)
        !fuse_s2_r |=> WATCHDOG_RUN == $past(rcc_r[rstc_pkg::BIT_SOFT_WATCHDOG_ENABLE]))
        else $error("software enable not followed");

    // keep outputs must follow what software wrote, not merely mirror the register
    a_flash_keep: assert property (@(posedge SYS_CLK) // RULE4
        disable iff (POWER_ON_RST)
        wr_en && hit_rcc && PSTRB[1] |=>
        FLASH_REGULATOR_SLEEP_KEEP == $past(PWDATA[rstc_pkg::BIT_FLASHRG]))
        else $error("flash keep not written");
    a_main_keep: assert property (@(posedge SYS_CLK) // RULE6
        disable iff (POWER_ON_RST)
        wr_en && hit_rcc && PSTRB[1] |=>
        MAIN_REGULATOR_SLEEP_KEEP == $past(PWDATA[rstc_pkg::BIT_MAINRG]))
        else $error("main keep not written");
    a_sw_write: assert property (@(posedge SYS_CLK) // RULE11
        disable iff (SYS_RST || POWER_ON_RST)
        wr_en && hit_rcc && PSTRB[0] && !PWDATA[rstc_pkg::BIT_SOFT]
        && !evt_bus.evt[rstc_pkg::BIT_SOFT] |=> !rcc_r[rstc_pkg::BIT_SOFT])
        else $error("software clear lost");
    a_write_lands: assert property (@(posedge SYS_CLK) // RULE11
        disable iff (POWER_ON_RST)
        wr_en && hit_rcc && PSTRB[1:0] == 2'b11 && evt_bus.evt == 16'h0000 |=>
        rcc_r == ($past(PWDATA[15:0]) & rstc_pkg::IMPL_MASK))
        else $error("full write not stored");
    a_rd_capture: assert property (@(posedge SYS_CLK) // RULE11
        disable iff (SYS_RST)
        rd_en && hit_rcc |=> PRDATA == {16'h0000, $past(rcc_r)})
        else $error("read data not captured");

    // flags outlive core resets; only software or power-on may drop them
    a_persist: assert property (@(posedge SYS_CLK) // RULE14
        disable iff (POWER_ON_RST)
        rcc_r[rstc_pkg::BIT_PIN] && !(wr_en && hit_rcc) |=> rcc_r[rstc_pkg::BIT_PIN])
        else $error("pin flag lost");
    a_persist_trap: assert property (@(posedge SYS_CLK) // RULE14
        disable iff (POWER_ON_RST)
        rcc_r[rstc_pkg::BIT_TRAP] && !(wr_en && hit_rcc) |=> rcc_r[rstc_pkg::BIT_TRAP])
        else $error("trap flag lost");
endmodule : rstc_top
`default_nettype wire

// File: tb.sv
// testbench: drives apb and the cause inputs of the reset cause block, checks reads
// assumes: one 100 MHz clock, cause inputs held low during power-on reset
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk         = 1'b0;
    logic        rst         = 1'b1;
    logic        por         = 1'b1;
    logic [8:0]  ev          = 9'h000;
    logic        fuse        = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h00000000;
    logic [3:0]  pstrb       = 4'hf;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         wd_run;
    wire         flash_keep;
    wire         main_keep;
    wire         irq;
    int          miscompares = 0;
    int          checks      = 0;
    logic [31:0] q;
    logic        e;
    logic [31:0] b;
    // register bit set by each cause input, same order as ev
    int          evbit [9]   = '{15, 14, 9, 7, 6, 4, 1, 3, 2};
    localparam logic [7:0] CAU = rstc_pkg::OFF_RESET_CAUSE_CONTROL;
    localparam logic [7:0] STA = rstc_pkg::OFF_IRQ_STATUS;
    localparam logic [7:0] MSK = rstc_pkg::OFF_IRQ_MASK;

    rstc_top uut (
        .SYS_CLK                    (clk),
        .SYS_RST                    (rst),
        .POWER_ON_RST               (por),
        .TRAP_CONFLICT              (ev[0]),
        .BAD_OPCODE_POINTER         (ev[1]),
        .CONFIG_MISMATCH            (ev[2]),
        .MASTER_CLEAR_PIN           (ev[3]),
        .SOFT_RESET                 (ev[4]),
        .WATCHDOG_TIMEOUT           (ev[5]),
        .BROWNOUT                   (ev[6]),
        .SLEEP_WAKE                 (ev[7]),
        .IDLE_WAKE                  (ev[8]),
        .WATCHDOG_FUSE_ENABLE       (fuse),
        .PSEL                       (psel),
        .PENABLE                    (penable),
        .PWRITE                     (pwrite),
        .PADDR                      (paddr),
        .PWDATA                     (pwdata),
        .PSTRB                      (pstrb),
        .PRDATA                     (prdata),
        .PREADY                     (pready),
        .PSLVERR                    (pslverr),
        .WATCHDOG_RUN               (wd_run),
        .FLASH_REGULATOR_SLEEP_KEEP (flash_keep),
        .MAIN_REGULATOR_SLEEP_KEEP  (main_keep),
        .IRQ                        (irq)
    );

    always #5 clk = ~clk;

    task automatic close_out();
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high, bounded wait
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            miscompares++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(a, 1'b0, 32'h00000000);
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        rd(CAU);
        check("cause_por", q, 32'h00000003);
        check("ready", {31'h0, pready}, 32'h00000001);
        rd(MSK);
        check("mask_rst", q, 32'h00000000);
        rd(8'h0c);
        check("unmapped_err", {31'h0, e}, 32'h00000001);
        check("unmapped_rd", q, 32'h00000000);
        wr(CAU, 32'h0000ffff);
        rd(CAU);
        check("cause_all", q, 32'h0000cbff);
        check("keep_on", {30'h0, flash_keep, main_keep}, 32'h00000003);
        repeat (5) @(posedge clk);
        check("wd_soft_on", {31'h0, wd_run}, 32'h00000001);
        wr(CAU, 32'h00000000);
        repeat (5) @(posedge clk);
        check("keep_off", {30'h0, flash_keep, main_keep}, 32'h00000000);
        check("wd_soft_off", {31'h0, wd_run}, 32'h00000000);
        // keep bits apart, then a low-lane write must leave the upper byte alone
        wr(CAU, 32'h00000800);
        @(posedge clk);
        check("keep_split", {30'h0, flash_keep, main_keep}, 32'h00000002);
        pstrb <= 4'h1;
        wr(CAU, 32'h0000f7df);
        pstrb <= 4'hf;
        rd(CAU);
        check("cause_lane", q, 32'h000008df);
        fuse <= 1'b1;
        repeat (5) @(posedge clk);
        check("wd_fuse", {31'h0, wd_run}, 32'h00000001);
        fuse <= 1'b0;
        // each cause sets only its own flag, and raises irq when unmasked
        for (int i = 0; i < 9; i++)
        begin
            b = 32'h00000001 << evbit[i];
            wr(CAU, 32'h00000000);
            wr(STA, 32'h0000ffff);
            wr(MSK, b);
            ev[i] <= 1'b1;
            repeat (4) @(posedge clk);
            ev[i] <= 1'b0;
            rd(CAU);
            check("cause_evt", q, b);
            check("irq_on", {31'h0, irq}, 32'h00000001);
            wr(STA, b);
            @(posedge clk);
            check("irq_clr", {31'h0, irq}, 32'h00000000);
        end
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rd(CAU);
        check("cause_keep", q, 32'h00000004);
        // masked event leaves irq low until unmasked
        wr(MSK, 32'h00000000);
        ev[0] <= 1'b1;
        repeat (4) @(posedge clk);
        ev[0] <= 1'b0;
        check("irq_masked", {31'h0, irq}, 32'h00000000);
        wr(MSK, 32'h00008000);
        @(posedge clk);
        check("irq_unmask", {31'h0, irq}, 32'h00000001);
        close_out();
    end
endmodule // tb
`default_nettype wire
